// file: low_power_mode_control.sv
// Low-power mode controller: power control register, Idle and Power-down.
// Assumes the CPU end writes the register over lpm_if and reports
// interrupts, watchdog events; pins come in unsynchronised.
//
// Function
// - Idle halts CPU, peripherals keep running
// - Power-down stops oscillator, entered only by bit
// - Idle entered after write of bit 0
// - Enabled interrupt clears idle bit, ends Idle
// - Two general flags, no hardware effect
// - External reset held 24 clocks ends Idle
// - Watchdog reset also ends Idle
// - Power-down entered after write of bit 1
// - Reset or level external interrupt ends Power-down
// - Waker holds interrupt low until oscillator stable
// - After wake, service interrupt then continue
// - Port two driven from latch in Power-down
// - Strobes high in Idle, low in Power-down
// - Register at 87H, reset 00H, byte writes
// - Bit 7 doubles serial baud rate when Timer 1 is the baud source
// - Bit 6 disables auxiliary RAM
// - Bit 5 stops address latch strobe toggling
// - Watchdog load enable cleared on watchdog load
// - Both bits written: Power-down wins
// - Wake interrupt should have highest priority
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module low_power_mode_control (
	// Link to CPU side
	lpm_if.device      link,
	// Pins
	input  wire logic       resetPin,
	input  wire logic       extIrqZeroPin,
	input  wire logic       extIrqOnePin,
	input  wire logic       extIrqZeroEnabled,
	input  wire logic       extIrqOneEnabled,
	input  wire logic       extIrqZeroLevel,
	input  wire logic       extIrqOneLevel,
	input  wire logic       externalFetch,
	input  wire logic       timerOneBaud,
	input  wire logic [7:0] portTwoLatch,
	input  wire logic [7:0] portTwoAddress,
	input  wire logic       latchStrobeRun,
	input  wire logic       progStrobeRun,
	// Pin and control outputs
	output logic       latchStrobe,
	output logic       programStoreStrobe,
	output logic [7:0] portTwoOut,
	output logic       portZeroFloat,
	output logic       baudDouble,
	output logic       auxRamOff
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] rstSync_q, irq0Sync_q, irq1Sync_q;
	logic       rstLvl_q, irq0Lvl_q, irq1Lvl_q;
	logic       rstLvl_d, irq0Lvl_d, irq1Lvl_d;

	always_comb begin
		rstLvl_d  = (rstSync_q[1] == rstSync_q[2]) ? rstSync_q[2] : rstLvl_q;
		irq0Lvl_d = (irq0Sync_q[1] == irq0Sync_q[2]) ? irq0Sync_q[2] : irq0Lvl_q;
		irq1Lvl_d = (irq1Sync_q[1] == irq1Sync_q[2]) ? irq1Sync_q[2] : irq1Lvl_q;
	end

	always_ff @(posedge link.clock) begin
		if (link.rst) begin
			rstSync_q  <= 3'h0;
			irq0Sync_q <= 3'h7;
			irq1Sync_q <= 3'h7;
			rstLvl_q   <= 1'b0;
			irq0Lvl_q  <= 1'b1;
			irq1Lvl_q  <= 1'b1;
		end else begin
			rstSync_q  <= {rstSync_q[1:0], resetPin};
			irq0Sync_q <= {irq0Sync_q[1:0], extIrqZeroPin};
			irq1Sync_q <= {irq1Sync_q[1:0], extIrqOnePin};
			rstLvl_q   <= rstLvl_d;
			irq0Lvl_q  <= irq0Lvl_d;
			irq1Lvl_q  <= irq1Lvl_d;
		end
	end

	// ----------------------------------------------------------------
	// External reset qualifier
	// ----------------------------------------------------------------
	logic [4:0] rstCount_q, rstCount_d;
	logic       extReset;

	always_comb begin
		rstCount_d = 5'h00;
		if (rstLvl_q && rstCount_q != lpm_pkg::ResetCountMax)
			rstCount_d = rstCount_q + 5'h01;
		else if (rstLvl_q)
			rstCount_d = rstCount_q;
	end
	// Reset counts only once held for the full two machine cycles
	assign extReset = (rstCount_q == lpm_pkg::ResetCountMax);

	always_ff @(posedge link.clock) begin
		if (link.rst)
			rstCount_q <= 5'h00;
		else
			rstCount_q <= rstCount_d;
	end

	// ----------------------------------------------------------------
	// Register and mode machine
	// ----------------------------------------------------------------
	lpm_pkg::mode_t mode_q, mode_d;
	logic [7:0] power_control_q, power_control_d;
	logic [4:0] settle_q, settle_d;
	logic       osc_q, osc_d;
	logic       cpuEn_q, cpuEn_d;
	logic       coreRst_q, coreRst_d;
	logic       wake0, wake1, anyReset, regWrite;

	// Power-down wake needs level-sensitive, enabled and pin low
	assign wake0 = extIrqZeroEnabled && extIrqZeroLevel && !irq0Lvl_q;
	assign wake1 = extIrqOneEnabled && extIrqOneLevel && !irq1Lvl_q;
	assign anyReset = extReset || link.watchdogReset;
	assign regWrite = link.sfrWr && link.sfrAddr == lpm_pkg::PowerControlAddr;

	always_comb begin
		mode_d    = mode_q;
		power_control_d    = power_control_q;
		settle_d  = settle_q;
		osc_d     = osc_q;
		cpuEn_d   = cpuEn_q;
		coreRst_d = 1'b0;
		if (regWrite)
			power_control_d = link.sfrWdata;
		// Load clears the enable; a fresh write of the bit wins
		if (link.watchdogLoad && !(regWrite &&
				link.sfrWdata[lpm_pkg::BitWdLoadEn]))
			power_control_d[lpm_pkg::BitWdLoadEn] = 1'b0;
		unique case (mode_q)
			lpm_pkg::ModeRun: begin
				if (regWrite && link.sfrWdata[lpm_pkg::BitPowerDown]) begin
					mode_d  = lpm_pkg::ModeDown;
					osc_d   = 1'b0;
					cpuEn_d = 1'b0;
				end else if (regWrite && link.sfrWdata[lpm_pkg::BitIdle]) begin
					mode_d  = lpm_pkg::ModeIdle;
					cpuEn_d = 1'b0;
				end
			end
			lpm_pkg::ModeIdle: begin
				if (link.irqPending) begin
					power_control_d[lpm_pkg::BitIdle] = 1'b0;
					mode_d  = lpm_pkg::ModeRun;
					cpuEn_d = 1'b1;
				end
			end
			lpm_pkg::ModeDown: begin
				if (settle_q != 5'h00) begin
					settle_d = settle_q - 5'h01;
					if (settle_q == 5'h01) begin
						// Core resumes and takes the wake interrupt
						power_control_d[lpm_pkg::BitPowerDown] = 1'b0;
						mode_d  = lpm_pkg::ModeRun;
						cpuEn_d = 1'b1;
					end
				end else if (wake0 || wake1) begin
					osc_d    = 1'b1;
					settle_d = lpm_pkg::SettleCountMax;
				end
			end
		endcase
		if (anyReset) begin
			// Any reset ends either low-power mode
			mode_d    = lpm_pkg::ModeRun;
			power_control_d    = lpm_pkg::PowerControlReset;
			osc_d     = 1'b1;
			cpuEn_d   = 1'b1;
			settle_d  = 5'h00;
			coreRst_d = 1'b1;
		end
	end

	always_ff @(posedge link.clock) begin
		if (link.rst) begin
			mode_q    <= lpm_pkg::ModeRun;
			power_control_q    <= lpm_pkg::PowerControlReset;
			settle_q  <= 5'h00;
			osc_q     <= 1'b1;
			cpuEn_q   <= 1'b1;
			coreRst_q <= 1'b1;
		end else begin
			mode_q    <= mode_d;
			power_control_q    <= power_control_d;
			settle_q  <= settle_d;
			osc_q     <= osc_d;
			cpuEn_q   <= cpuEn_d;
			coreRst_q <= coreRst_d;
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	logic       ale_q, ale_d, program_store_strobe_q, program_store_strobe_d, p0f_q, p0f_d;
	logic       svc_q, svc_d, baudDbl_q, baudDbl_d;
	logic [7:0] p2_q, p2_d;

	always_comb begin
		svc_d = mode_q == lpm_pkg::ModeIdle && link.irqPending;
		// Doubling applies only with Timer 1 as baud source
		baudDbl_d = power_control_q[lpm_pkg::BitBaudDbl] && timerOneBaud;
		p0f_d = externalFetch && mode_q != lpm_pkg::ModeRun;
		unique case (mode_q)
			lpm_pkg::ModeIdle: begin
				ale_d  = 1'b1;
				program_store_strobe_d = 1'b1;
				p2_d   = externalFetch ? portTwoAddress : portTwoLatch;
			end
			lpm_pkg::ModeDown: begin
				ale_d  = 1'b0;
				program_store_strobe_d = 1'b0;
				p2_d   = portTwoLatch;
			end
			default: begin
				ale_d  = power_control_q[lpm_pkg::BitQuiet] ? 1'b1 : latchStrobeRun;
				program_store_strobe_d = progStrobeRun;
				p2_d   = externalFetch ? portTwoAddress : portTwoLatch;
			end
		endcase
	end

	always_ff @(posedge link.clock) begin
		if (link.rst) begin
			ale_q  <= 1'b1;
			program_store_strobe_q <= 1'b1;
			p0f_q  <= 1'b0;
			p2_q   <= 8'hFF;
			svc_q  <= 1'b0;
			baudDbl_q <= 1'b0;
		end else begin
			ale_q  <= ale_d;
			program_store_strobe_q <= program_store_strobe_d;
			p0f_q  <= p0f_d;
			p2_q   <= p2_d;
			svc_q  <= svc_d;
			baudDbl_q <= baudDbl_d;
		end
	end

	assign latchStrobe        = ale_q;
	assign programStoreStrobe = program_store_strobe_q;
	assign portTwoOut         = p2_q;
	assign portZeroFloat      = p0f_q;
	assign baudDouble = baudDbl_q;
	assign auxRamOff  = power_control_q[lpm_pkg::BitAuxOff];
	assign link.powerControl  = power_control_q;
	assign link.cpuClockEn    = cpuEn_q;
	assign link.oscEnable     = osc_q;
	assign link.periphClockEn = osc_q;
	assign link.coreReset     = coreRst_q;
	assign link.irqServiced   = svc_q;
endmodule // low_power_mode_control

// file: lpm_pkg.sv
// Package for the low-power mode controller and its CPU-side partner.
// Assumes one 40 MHz clock and synchronous active-high reset everywhere.
package lpm_pkg;
	// ----------------------------------------------------------------
	// Power control register
	// ----------------------------------------------------------------
	localparam logic [7:0] PowerControlAddr  = 8'h87;
	localparam logic [7:0] PowerControlReset = 8'h00;
	localparam int BitIdle      = 0;
	localparam int BitPowerDown = 1;
	localparam int BitFlagLow   = 2;
	localparam int BitFlagHigh  = 3;
	localparam int BitWdLoadEn  = 4;
	localparam int BitQuiet     = 5;
	localparam int BitAuxOff    = 6;
	localparam int BitBaudDbl   = 7;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ClockMhz          = 40;
	localparam int ResetHoldOscPer   = 24;
	localparam int ResetHoldCycles   = ResetHoldOscPer;
	localparam int OscSettleNs       = 500;
	localparam int OscSettleCycles   = (OscSettleNs * ClockMhz + 999) / 1000;
	localparam logic [4:0] ResetCountMax = 5'(ResetHoldCycles);
	localparam logic [4:0] SettleCountMax = 5'(OscSettleCycles);
	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ModeRun  = 3'b001,
		ModeIdle = 3'b010,
		ModeDown = 3'b100
	} mode_t;
endpackage

// file: lpm_if.sv
// Interface joining the power mode controller and the CPU-side partner.
// Assumes both ends share clock and rst.
`timescale 1ns/1ps
interface lpm_if (
	input wire logic clock,
	input wire logic rst
);
	logic       sfrWr;
	logic [7:0] sfrAddr;
	logic [7:0] sfrWdata;
	logic [7:0] powerControl;
	logic       irqPending;
	logic       irqServiced;
	logic       watchdogReset;
	logic       watchdogLoad;
	logic       cpuClockEn;
	logic       oscEnable;
	logic       periphClockEn;
	logic       coreReset;
	modport device (
		input  clock, rst, sfrWr, sfrAddr, sfrWdata, irqPending,
		input  watchdogReset, watchdogLoad,
		output powerControl, cpuClockEn, oscEnable, periphClockEn,
		output coreReset, irqServiced
	);
	modport host (
		input  clock, rst, powerControl, cpuClockEn, oscEnable,
		input  periphClockEn, coreReset, irqServiced,
		output sfrWr, sfrAddr, sfrWdata, irqPending, watchdogReset,
		output watchdogLoad
	);
endinterface

// file: lpm_cpu_end.sv
// CPU-side partner: turns software port writes into register writes,
// forwards interrupt and watchdog events, reports controller status.
// Assumes the controller end sits on the same lpm_if.
`timescale 1ns/1ps
module lpm_cpu_end (
	// Link to controller
	lpm_if.host        link,
	// Software port
	input  wire logic [7:0] swAddr,
	input  wire logic [7:0] swWdata,
	input  wire logic       swWr,
	input  wire logic       swRd,
	output logic [7:0] swRdata,
	// Events
	input  wire logic       irqRequest,
	input  wire logic       wdReset,
	input  wire logic       wdLoad
);
	// ----------------------------------------------------------------
	// Forwarding
	// ----------------------------------------------------------------
	logic       wr_q, wr_d, irq_q, irq_d, wdr_q, wdr_d, wdl_q, wdl_d;
	logic [7:0] addr_q, addr_d, data_q, data_d, rd_q, rd_d;

	always_comb begin
		wr_d   = swWr && link.cpuClockEn;
		addr_d = swAddr;
		data_d = swWdata;
		irq_d  = irqRequest;
		wdr_d  = wdReset;
		// Software must have set the load enable first
		wdl_d  = wdLoad && link.powerControl[lpm_pkg::BitWdLoadEn];
		rd_d   = 8'h00;
		if (swRd && swAddr == lpm_pkg::PowerControlAddr)
			rd_d = link.powerControl;
		else if (swRd && swAddr == 8'h00)
			rd_d = {5'h00, link.coreReset, link.oscEnable, link.cpuClockEn};
	end

	always_ff @(posedge link.clock) begin
		if (link.rst) begin
			wr_q   <= 1'b0;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			irq_q  <= 1'b0;
			wdr_q  <= 1'b0;
			wdl_q  <= 1'b0;
			rd_q   <= 8'h00;
		end else begin
			wr_q   <= wr_d;
			addr_q <= addr_d;
			data_q <= data_d;
			irq_q  <= irq_d;
			wdr_q  <= wdr_d;
			wdl_q  <= wdl_d;
			rd_q   <= rd_d;
		end
	end

	assign link.sfrWr         = wr_q;
	assign link.sfrAddr       = addr_q;
	assign link.sfrWdata      = data_q;
	assign link.irqPending    = irq_q;
	assign link.watchdogReset = wdr_q;
	assign link.watchdogLoad  = wdl_q;
	assign swRdata            = rd_q;
endmodule // lpm_cpu_end

// file: low_power_mode_control_props.sv
// Checker for the link between the power mode controller and CPU end.
// Assumes one clock and synchronous active-high rst on both ends.
`timescale 1ns/1ps
module low_power_mode_control_props (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// CPU end outputs
	input wire logic       sfrWr,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic       irqPending,
	input wire logic       watchdogReset,
	input wire logic       watchdogLoad,
	// Controller outputs
	input wire logic [7:0] powerControl,
	input wire logic       irqServiced,
	input wire logic       cpuClockEn,
	input wire logic       oscEnable,
	input wire logic       periphClockEn,
	input wire logic       coreReset
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	logic pcWr;
	assign pcWr = sfrWr && sfrAddr == lpm_pkg::PowerControlAddr && cpuClockEn;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence pd_req;
		pcWr && sfrWdata[1];
	endsequence
	sequence wake_done;
		$rose(cpuClockEn) && !powerControl[1];
	endsequence
	reset_value_a: assert property ($fell(rst) |-> powerControl == 8'h00)
		else $error("power control not cleared by reset");
	write_bits_a: assert property (pcWr && !watchdogLoad && !watchdogReset
		|=> powerControl[7:2] == $past(sfrWdata[7:2]))
		else $error("written bits not stored");
	idle_entry_a: assert property (pcWr && sfrWdata[1:0] == 2'h1
		|=> !cpuClockEn && oscEnable) else $error("idle not entered");
	pd_entry_a: assert property (pd_req |=> !cpuClockEn && !oscEnable)
		else $error("power-down not entered");
	osc_stop_a: assert property ($fell(oscEnable) |-> $past(pcWr)
		&& $past(sfrWdata[1])) else $error("oscillator stopped unasked");
	periph_clock_a: assert property (periphClockEn == oscEnable)
		else $error("peripheral clock differs from oscillator");
	idle_exit_a: assert property (irqPending && oscEnable && !cpuClockEn
		&& powerControl[1:0] == 2'h1 |=> cpuClockEn && !powerControl[0]
		&& irqServiced)
		else $error("interrupt did not end idle");
	wd_reset_a: assert property (watchdogReset && oscEnable
		|=> powerControl == 8'h00 && cpuClockEn)
		else $error("watchdog reset ignored");
	wd_load_a: assert property (watchdogLoad && powerControl[4] && !sfrWr
		|=> !powerControl[4]) else $error("load enable not cleared");
	wake_time_a: assert property ($rose(oscEnable) && !coreReset
		|-> ##[19:21] wake_done) else $error("wake-up not completed");
endmodule // low_power_mode_control_props

// file: low_power_mode_control_tb.sv
// Testbench: controller and CPU end joined by lpm_if, driven through
// the software port. Assumes a 40 MHz clock and synchronous reset.
`timescale 1ns/1ps
module low_power_mode_control_tb;
	logic       clock = 1'h0;
	logic       rst = 1'h1;
	logic [7:0] swAddr = 8'h00, swWdata = 8'h00, swRdata, p2;
	logic       swWr = 1'h0, swRd = 1'h0, irqReq = 1'h0, wdRst = 1'h0;
	logic       wdLd = 1'h0, resetPin = 1'h0, pinZero = 1'h1, enZero = 1'h0;
	logic       pinOne = 1'h1, lvlZero = 1'h1, extFetch = 1'h0, baud = 1'h1;
	logic       ale, program_store_strobe, p0f, baudDbl, auxOff, aleRun = 1'h0;
	int         err_total = 0, num_checks = 0, cycles = 0;
	lpm_if link (.clock(clock), .rst(rst));
	low_power_mode_control i_low_power_mode_control (.link(link),
		.resetPin(resetPin), .extIrqZeroPin(pinZero), .extIrqOnePin(pinOne),
		.extIrqZeroEnabled(enZero), .extIrqOneEnabled(1'h1),
		.extIrqZeroLevel(lvlZero), .extIrqOneLevel(1'h1),
		.externalFetch(extFetch), .timerOneBaud(baud), .portTwoLatch(8'hA5),
		.portTwoAddress(8'h5A), .latchStrobeRun(aleRun), .progStrobeRun(1'h0),
		.latchStrobe(ale), .programStoreStrobe(program_store_strobe), .portTwoOut(p2),
		.portZeroFloat(p0f), .baudDouble(baudDbl), .auxRamOff(auxOff));
	lpm_cpu_end i_lpm_cpu_end (.link(link), .swAddr(swAddr),
		.swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata),
		.irqRequest(irqReq), .wdReset(wdRst), .wdLoad(wdLd));
	low_power_mode_control_props i_props (.clock(clock), .rst(rst),
		.sfrWr(link.sfrWr), .sfrAddr(link.sfrAddr), .sfrWdata(link.sfrWdata),
		.irqPending(link.irqPending), .watchdogReset(link.watchdogReset),
		.watchdogLoad(link.watchdogLoad), .powerControl(link.powerControl),
		.irqServiced(link.irqServiced), .cpuClockEn(link.cpuClockEn),
		.oscEnable(link.oscEnable), .periphClockEn(link.periphClockEn),
		.coreReset(link.coreReset));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		swAddr <= a;
		swWdata <= d;
		swWr <= 1'h1;
		@(posedge clock);
		swWr <= 1'h0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clock);
		swAddr <= a;
		swRd <= 1'h1;
		@(posedge clock);
		swRd <= 1'h0;
		#1;
		chk(swRdata, exp);
	endtask
	task automatic waitcpu;
		#1;
		for (int i = 0; i < 40 && link.cpuClockEn !== 1'h1; i++) begin
			@(posedge clock);
			#1;
		end
		chk({7'h00, link.cpuClockEn}, 8'h01);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, timeout and tests
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		rd(8'h87, 8'h00);
		rd(8'h11, 8'h00);
		rd(8'h00, 8'h03);
		wr(8'h87, 8'hEC);
		rd(8'h87, 8'hEC);
		chk({7'h00, ale}, 8'h01);
		chk({6'h00, baudDbl, auxOff}, 8'h03);
		@(posedge clock) baud <= 1'h0;
		repeat (2) @(posedge clock);
		#1;
		chk({6'h00, baudDbl, auxOff}, 8'h01);
		$display("test flags done");
		@(posedge clock) extFetch <= 1'h1;
		wr(8'h87, 8'h0D);
		chk({link.cpuClockEn, link.oscEnable, link.periphClockEn, ale, program_store_strobe,
			p0f, 2'h0}, 8'h7C);
		chk(p2, 8'h5A);
		wr(8'h87, 8'h00);
		chk(link.powerControl, 8'h0D);
		@(posedge clock) irqReq <= 1'h1;
		@(posedge clock) irqReq <= 1'h0;
		waitcpu();
		chk(link.powerControl, 8'h0C);
		wr(8'h87, 8'h01);
		@(posedge clock) wdRst <= 1'h1;
		@(posedge clock) wdRst <= 1'h0;
		waitcpu();
		chk(link.powerControl, 8'h00);
		wr(8'h87, 8'h05);
		@(posedge clock) resetPin <= 1'h1;
		repeat (32) @(posedge clock);
		resetPin <= 1'h0;
		repeat (4) @(posedge clock);
		waitcpu();
		chk(link.powerControl, 8'h00);
		$display("test idle done");
		wr(8'h87, 8'h0F);
		chk({link.cpuClockEn, link.oscEnable, ale, program_store_strobe, p0f,
			3'h0}, 8'h08);
		chk(p2, 8'hA5);
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			enZero <= k[0];
			lvlZero <= ~k[0];
			pinZero <= 1'h0;
			repeat (40) @(posedge clock);
			#1;
			chk({7'h00, link.oscEnable}, 8'h00);
			@(posedge clock) pinZero <= 1'h1;
		end
		@(posedge clock);
		enZero <= 1'h1;
		lvlZero <= 1'h1;
		pinZero <= 1'h0;
		waitcpu();
		@(posedge clock) pinZero <= 1'h1;
		repeat (4) @(posedge clock);
		#1;
		chk(link.powerControl & 8'hFE, 8'h0C);
		wr(8'h87, 8'h02);
		@(posedge clock) pinOne <= 1'h0;
		waitcpu();
		@(posedge clock) pinOne <= 1'h1;
		#1;
		chk(link.powerControl, 8'h00);
		$display("test power-down done");
		wr(8'h87, 8'h10);
		rd(8'h87, 8'h10);
		@(posedge clock) wdLd <= 1'h1;
		@(posedge clock) wdLd <= 1'h0;
		repeat (3) @(posedge clock);
		#1;
		chk(link.powerControl, 8'h00);
		$display("test watchdog load done");
		chk({7'h00, ale}, 8'h00);
		@(posedge clock) aleRun <= 1'h1;
		repeat (2) @(posedge clock);
		#1;
		chk({7'h00, ale}, 8'h01);
		$display("test strobe done");
		report_and_stop();
	end
endmodule // low_power_mode_control_tb
